// file: vfu_pkg.sv
// Shared constants, types and pixel lane helpers for the video input format unpacker
package vfu_pkg;
  localparam int VFU_LINES = 12;
  localparam int VFU_BYTE = 8;
  localparam int VFU_PIX = 24;
  localparam int VFU_FIFO_DEPTH = 8;
  localparam int VFU_HALF_DIV = 2;
  localparam logic [1:0] VFU_PH_CB = 2'h0;
  localparam logic [1:0] VFU_PH_Y0 = 2'h1;
  localparam logic [1:0] VFU_PH_CR = 2'h2;
  localparam logic [1:0] VFU_PH_Y1 = 2'h3;
  localparam logic [15:0] VFU_INDEX_PAD = 16'h0000;
  localparam logic [11:0] VFU_IDLE_LINES = 12'h000;

  typedef enum logic [1:0] {
    VFU_FMT_ITL422,
    VFU_FMT_INDEX,
    VFU_FMT_RGB444
  } vfu_fmt_type;

  // Pixel word layout is {red or Cr, green or Y, blue or Cb}
  function automatic logic [11:0] vfu_gb_word(input logic [23:0] p);
    vfu_gb_word = {p[12], p[11], p[10], p[7:3], p[8], p[2:0]};
  endfunction : vfu_gb_word

  function automatic logic [11:0] vfu_r_word(input logic [23:0] p);
    vfu_r_word = {p[23:19], p[15:13], p[18:16], p[9]};
  endfunction : vfu_r_word

  function automatic logic [23:0] vfu_unpack(input logic [11:0] gb, input logic [11:0] rw);
    vfu_unpack = {rw[11:7], rw[3:1], rw[6:4], gb[11:9], rw[0], gb[3], gb[8:4], gb[2:0]};
  endfunction : vfu_unpack
endpackage : vfu_pkg

// file: vfu_link_if.sv
// Pixel port between the video source and the encoder input
`timescale 1ns/1ps
`default_nettype none
interface vfu_link_if;
  logic pix_clk;
  logic [11:0] pixel_data_lines;
  modport host (output pix_clk, output pixel_data_lines);
  modport device (input pix_clk, input pixel_data_lines);
endinterface : vfu_link_if
`default_nettype wire

// file: vfu_device.sv
// Encoder end: pixel port capture, format unpacking and output FIFO
`timescale 1ns/1ps
`default_nettype none
module vfu_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  // Depth must be a power of two so the pointers wrap by themselves
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } vfu_fifo_state_type;
  vfu_fifo_state_type s_r;
  vfu_fifo_state_type s_nxt;
  logic push;
  logic pop;

  assign in_ready = s_r.cnt != (AW+1)'(DEPTH);
  assign out_valid = s_r.cnt != '0;
  assign out_data = s_r.mem[s_r.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wr] = in_data;
      s_nxt.wr = s_r.wr + 1'b1;
    end
    if (pop) begin
      s_nxt.rd = s_r.rd + 1'b1;
    end
    case ({push, pop})
      2'b10: s_nxt.cnt = s_r.cnt + 1'b1;
      2'b01: s_nxt.cnt = s_r.cnt - 1'b1;
      default: s_nxt.cnt = s_r.cnt;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule : vfu_fifo

module vfu_device #(
  parameter int FIFO_DEPTH = vfu_pkg::VFU_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  vfu_link_if.device link,
  input wire vfu_pkg::vfu_fmt_type fmt,
  input wire logic slot_sel,
  input wire logic edge_sel,
  output logic [23:0] pix_data,
  output logic pix_valid,
  input wire logic pix_ready,
  output logic capture_ready,
  output logic overflow
);
  typedef struct packed {
    logic clk_prev;
    logic [1:0] phase;
    logic [7:0] cb;
    logic [7:0] y0;
    logic [7:0] cr;
    logic [11:0] first_word;
    logic have_first;
    logic push_v;
    logic [23:0] push_d;
    logic ovf;
    logic cap_rdy;
  } vfu_dev_state_type;
  vfu_dev_state_type s_r;
  vfu_dev_state_type s_nxt;
  logic fifo_in_ready;
  logic rise;
  logic fall;
  logic first_edge;
  logic second_edge;
  logic [11:0] d;

  assign d = link.pixel_data_lines;
  assign rise = link.pix_clk && !s_r.clk_prev;
  assign fall = !link.pix_clk && s_r.clk_prev;
  assign first_edge = edge_sel ? fall : rise;
  assign second_edge = edge_sel ? rise : fall;
  assign capture_ready = s_r.cap_rdy;
  assign overflow = s_r.ovf;

  always_comb begin
    s_nxt = s_r;
    s_nxt.clk_prev = link.pix_clk;
    s_nxt.push_v = 1'b0;
    s_nxt.cap_rdy = fifo_in_ready;
    // Link cannot be stalled, so a full FIFO drops the pixel and flags it
    if (s_r.push_v && !fifo_in_ready) begin
      s_nxt.ovf = 1'b1;
    end
    case (fmt)
      vfu_pkg::VFU_FMT_ITL422: begin
        if (rise) begin
          s_nxt.phase = s_r.phase + 1'b1;
          case (s_r.phase)
            vfu_pkg::VFU_PH_CB: s_nxt.cb = d[7:0];
            vfu_pkg::VFU_PH_Y0: s_nxt.y0 = d[7:0];
            vfu_pkg::VFU_PH_CR: begin
              s_nxt.cr = d[7:0];
              s_nxt.push_v = 1'b1;
              s_nxt.push_d = {d[7:0], s_r.y0, s_r.cb};
            end
            default: begin
              s_nxt.push_v = 1'b1;
              s_nxt.push_d = {s_r.cr, d[7:0], s_r.cb};
            end
          endcase
        end
      end
      vfu_pkg::VFU_FMT_INDEX: begin
        if (fall) begin
          s_nxt.push_v = 1'b1;
          s_nxt.push_d = {vfu_pkg::VFU_INDEX_PAD, d[7:0]};
        end
      end
      vfu_pkg::VFU_FMT_RGB444: begin
        if (first_edge) begin
          s_nxt.first_word = d;
          s_nxt.have_first = 1'b1;
        end else if (second_edge && s_r.have_first) begin
          s_nxt.have_first = 1'b0;
          s_nxt.push_v = 1'b1;
          if (slot_sel) begin
            s_nxt.push_d = vfu_pkg::vfu_unpack(d, s_r.first_word);
          end else begin
            s_nxt.push_d = vfu_pkg::vfu_unpack(s_r.first_word, d);
          end
        end
      end
      default: begin
        s_nxt.have_first = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  vfu_fifo #(
    .WIDTH(vfu_pkg::VFU_PIX),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(s_r.push_v),
    .in_ready(fifo_in_ready),
    .in_data(s_r.push_d),
    .out_valid(pix_valid),
    .out_ready(pix_ready),
    .out_data(pix_data)
  );
endmodule : vfu_device
`default_nettype wire

// file: vfu_host.sv
// Source end: pixel clock divider and per-format lane packing
`timescale 1ns/1ps
`default_nettype none
module vfu_host #(
  parameter int HALF_DIV = vfu_pkg::VFU_HALF_DIV
) (
  input wire logic clk,
  input wire logic rst,
  vfu_link_if.host link,
  input wire vfu_pkg::vfu_fmt_type fmt,
  input wire logic slot_sel,
  input wire logic edge_sel,
  input wire logic [23:0] src_data,
  input wire logic src_valid,
  output logic src_ready
);
  typedef struct packed {
    logic pclk;
    logic [7:0] div;
    logic [1:0] phase;
    logic hold_v;
    logic [23:0] hold_d;
    logic in_rdy;
    logic [11:0] lines;
    logic half;
  } vfu_host_state_type;
  vfu_host_state_type s_r;
  vfu_host_state_type s_nxt;
  logic tick;
  logic going_up;
  logic is_first;
  logic need;
  logic run;
  logic consume;
  logic [11:0] word;
  logic [11:0] gbw;
  logic [11:0] rw;

  assign tick = s_r.div == 8'(HALF_DIV - 1);
  assign going_up = !s_r.pclk;
  assign is_first = going_up ^ edge_sel;
  assign gbw = vfu_pkg::vfu_gb_word(s_r.hold_d);
  assign rw = vfu_pkg::vfu_r_word(s_r.hold_d);
  assign link.pix_clk = s_r.pclk;
  assign link.pixel_data_lines = s_r.lines;
  assign src_ready = s_r.in_rdy;

  always_comb begin
    need = 1'b0;
    run = 1'b1;
    consume = 1'b0;
    word = vfu_pkg::VFU_IDLE_LINES;
    case (fmt)
      vfu_pkg::VFU_FMT_ITL422: begin
        if (going_up) begin
          need = 1'b1;
          consume = s_r.phase[0];
          case (s_r.phase)
            vfu_pkg::VFU_PH_CB: word = {4'h0, s_r.hold_d[7:0]};
            vfu_pkg::VFU_PH_CR: word = {4'h0, s_r.hold_d[23:16]};
            default: word = {4'h0, s_r.hold_d[15:8]};
          endcase
        end
      end
      vfu_pkg::VFU_FMT_INDEX: begin
        if (!going_up) begin
          need = 1'b1;
          consume = 1'b1;
          word = {4'h0, s_r.hold_d[7:0]};
        end
      end
      vfu_pkg::VFU_FMT_RGB444: begin
        // A second edge with no first word sent runs free to realign the pair
        need = is_first || s_r.half;
        consume = !is_first;
        word = (is_first ^ slot_sel) ? gbw : rw;
      end
      default: begin
        need = 1'b0;
        run = 1'b0;
      end
    endcase
  end

  always_comb begin
    s_nxt = s_r;
    if (!tick) begin
      s_nxt.div = s_r.div + 1'b1;
    end else if (run && (!need || s_r.hold_v)) begin
      // Clock pauses at its level while a needed word is missing
      s_nxt.div = '0;
      s_nxt.pclk = !s_r.pclk;
      s_nxt.lines = word;
      if (need && fmt == vfu_pkg::VFU_FMT_ITL422) begin
        s_nxt.phase = s_r.phase + 1'b1;
      end
      if (need && fmt == vfu_pkg::VFU_FMT_RGB444) begin
        s_nxt.half = is_first;
      end
      if (need && consume) begin
        s_nxt.hold_v = 1'b0;
      end
    end
    if (s_r.in_rdy && src_valid) begin
      s_nxt.hold_v = 1'b1;
      s_nxt.hold_d = src_data;
    end
    s_nxt.in_rdy = !s_nxt.hold_v;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule : vfu_host
`default_nettype wire

// file: vfu_link_asserts.sv
// Wire checks on the pixel port between the two ends
`timescale 1ns/1ps
`default_nettype none
module vfu_link_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic pix_clk,
  input wire logic [11:0] pixel_data_lines,
  input wire vfu_pkg::vfu_fmt_type fmt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_RST_IDLE: assert property ($fell(rst) |-> !pix_clk && pixel_data_lines == 12'h000)
    else $error("port not idle after reset");
  AST_HALF_PERIOD: assert property ($changed(pix_clk) |=> $stable(pix_clk))
    else $error("pixel clock toggled too soon");
  AST_LINES_WITH_EDGE: assert property ($changed(pixel_data_lines) |-> $changed(pix_clk))
    else $error("lines moved without a clock edge");
  AST_IDX_UPPER: assert property (fmt == vfu_pkg::VFU_FMT_INDEX && $fell(pix_clk)
    |-> pixel_data_lines[11:8] == 4'h0)
    else $error("upper lines driven in index mode");
  AST_IDX_RISE: assert property (fmt == vfu_pkg::VFU_FMT_INDEX && $rose(pix_clk)
    |-> pixel_data_lines == 12'h000)
    else $error("index data on rising edge");
  AST_IDLE_HOLD: assert property (fmt == 2'h3 && $past(fmt) == 2'h3 |-> $stable(pix_clk))
    else $error("clock runs with no format");
  AST_ITL_UPPER: assert property (fmt == vfu_pkg::VFU_FMT_ITL422 && $rose(pix_clk)
    |-> pixel_data_lines[11:8] == 4'h0)
    else $error("upper lines driven in 4:2:2 mode");
  AST_ITL_FALL: assert property (fmt == vfu_pkg::VFU_FMT_ITL422 && $fell(pix_clk)
    |-> pixel_data_lines == 12'h000)
    else $error("4:2:2 data on falling edge");
  COV_ITL: cover property (fmt == vfu_pkg::VFU_FMT_ITL422 && $rose(pix_clk));
  COV_IDX: cover property (fmt == vfu_pkg::VFU_FMT_INDEX && $fell(pix_clk));
  COV_RGB: cover property (fmt == vfu_pkg::VFU_FMT_RGB444 && $fell(pix_clk));
endmodule : vfu_link_asserts
`default_nettype wire

// file: video_input_format_unpacker_tb.sv
// Self-checking bench joining the source and encoder ends
`timescale 1ns/1ps
`default_nettype none
module video_input_format_unpacker_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  vfu_pkg::vfu_fmt_type fmt = vfu_pkg::VFU_FMT_ITL422;
  logic slot_sel = 1'b0;
  logic edge_sel = 1'b0;
  logic [23:0] src_data = 24'h000000;
  logic src_valid = 1'b0;
  logic pix_ready = 1'b1;
  logic src_ready, pix_valid, capture_ready, overflow, pclk_q;
  logic wchk = 1'b0;
  logic [23:0] pix_data;
  logic [23:0] wpix = 24'h9c63a5;
  logic [23:0] exp_q[$];
  int failures = 0;
  int tests_run = 0;
  vfu_link_if link ();
  always #10 clk = ~clk;
  vfu_host u_vfu_host (.clk(clk), .rst(rst), .link(link.host), .fmt(fmt), .slot_sel(slot_sel),
    .edge_sel(edge_sel), .src_data(src_data), .src_valid(src_valid), .src_ready(src_ready));
  vfu_device u_vfu_device (.clk(clk), .rst(rst), .link(link.device), .fmt(fmt),
    .slot_sel(slot_sel), .edge_sel(edge_sel), .pix_data(pix_data), .pix_valid(pix_valid),
    .pix_ready(pix_ready), .capture_ready(capture_ready), .overflow(overflow));
  vfu_link_asserts u_vfu_link_asserts (.clk(clk), .rst(rst), .pix_clk(link.pix_clk),
    .pixel_data_lines(link.pixel_data_lines), .fmt(fmt));
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up();
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  task automatic timeout();
    failures++;
    wrap_up();
  endtask : timeout
  // Leading edge keeps valid from being set twice in one step
  task automatic send(input logic [23:0] p);
    int n;
    n = 0;
    @(posedge clk);
    src_valid <= 1'b1;
    src_data <= p;
    do begin
      @(posedge clk);
      n++;
    end while (src_ready !== 1'b1 && n < 300);
    if (n >= 300) timeout();
    src_valid <= 1'b0;
  endtask : send
  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) timeout();
    repeat (6) @(posedge clk);
  endtask : drain
  always @(posedge clk) begin
    pclk_q <= link.pix_clk;
    if (pix_valid === 1'b1 && pix_ready === 1'b1)
      check(pix_data, exp_q.size() != 0 ? exp_q.pop_front() : 24'hxxxxxx);
    if (wchk && link.pix_clk !== pclk_q && link.pix_clk)
      check({12'h000, link.pixel_data_lines}, {12'h000, wpix[12:10], wpix[7:3], wpix[8], wpix[2:0]});
    if (wchk && link.pix_clk !== pclk_q && !link.pix_clk)
      check({12'h000, link.pixel_data_lines}, {12'h000, wpix[23:19], wpix[15:13], wpix[18:16], wpix[9]});
  end
  initial begin
    logic [23:0] a, b;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // Device phase counts from reset, so 4:2:2 goes first
    for (int i = 0; i < 3; i++) begin
      a = 24'h5a3c17 ^ {3{i[7:0]}};
      b = 24'hc3e1f0 ^ {3{i[7:0]}};
      exp_q.push_back({b[23:16], a[15:8], a[7:0]});
      exp_q.push_back({b[23:16], b[15:8], a[7:0]});
      send(a);
      send(b);
    end
    drain();
    fmt <= vfu_pkg::vfu_fmt_type'(2'h3);
    repeat (20) @(posedge clk);
    fmt <= vfu_pkg::VFU_FMT_INDEX;
    for (int i = 0; i < 4; i++) begin
      a = {16'hbeef ^ {2{i[7:0]}}, 8'h81 ^ i[7:0]};
      exp_q.push_back({16'h0000, a[7:0]});
      send(a);
    end
    drain();
    fmt <= vfu_pkg::VFU_FMT_RGB444;
    for (int k = 0; k < 4; k++) begin
      slot_sel <= k[0];
      edge_sel <= k[1];
      for (int j = 0; j < 2; j++) begin
        a = 24'h3d72e6 ^ {3{k[7:0] + j[7:0]}};
        exp_q.push_back(a);
        send(a);
      end
      drain();
    end
    slot_sel <= 1'b0;
    edge_sel <= 1'b0;
    // Lines carry stale words until the first test pixel is held
    for (int j = 0; j < 4; j++) begin
      exp_q.push_back(wpix);
      send(wpix);
      if (j == 0) begin
        @(posedge clk);
        wchk <= 1'b1;
      end
    end
    drain();
    wchk <= 1'b0;
    // No stall on the link: a full FIFO must drop and flag it
    fmt <= vfu_pkg::VFU_FMT_INDEX;
    pix_ready <= 1'b0;
    for (int i = 0; i < 11; i++) begin
      if (i < 8) exp_q.push_back({16'h0000, 8'h40 + i[7:0]});
      send({16'h0000, 8'h40 + i[7:0]});
    end
    repeat (30) @(posedge clk);
    check({23'h000000, overflow}, 24'h000001);
    check({23'h000000, capture_ready}, 24'h000000);
    pix_ready <= 1'b1;
    drain();
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    check({23'h000000, overflow}, 24'h000000);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    wrap_up();
  end
endmodule : video_input_format_unpacker_tb
`default_nettype wire
